/* testbench/laser_cfg_chk.sv */
// Port checker for the configuration register page.
// Assumes it is bound to the top module, one clock domain.
`timescale 1ns/1ps
module laser_cfg_chk (
	input wire        clk,
	input wire        nrst,
	input wire        regRead,
	input wire        regWrite,
	input wire        regRdValid,
	input wire        regAccessDenied,
	input wire        topPasswordLevel,
	input wire        lowerPasswordLevel,
	input wire        tableReadPermit,
	input wire        tableReadWritePermit,
	input wire        modulationAutoRecall,
	input wire        tempConvDone,
	input wire        lutReadEn,
	input wire        apcSampleTick,
	input wire [7:0]  regAddr,
	input wire [7:0]  regRdData,
	input wire [7:0]  temperatureIndex,
	input wire [7:0]  lutAddr,
	input wire [1:0]  lutSelect,
	input wire [7:0]  quickTripCompare,
	input wire [7:0]  quickTripFlags,
	input wire [15:0] alarmCompare,
	input wire [15:0] alarmFlags,
	input wire [15:0] warningCompare,
	input wire [15:0] warningFlags
);
	reg  [7:0] idxQ, idxQ2;
	wire       rdOk;
	assign rdOk = topPasswordLevel | lowerPasswordLevel &
		(tableReadPermit | tableReadWritePermit);
	always @(posedge clk) begin
		idxQ <= temperatureIndex;
		idxQ2 <= idxQ;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_read_ok: assert property (regRead && rdOk |=> regRdValid)
		else $error("permitted read got no answer");
	a_read_deny: assert property (regRead && !rdOk |=>
		regAccessDenied && regRdData == 8'h00)
		else $error("refused read not flagged");
	a_valid_cause: assert property (regRdValid |-> $past(regRead))
		else $error("read data without a read");
	a_mod_lock: assert property (regWrite && regAddr == 8'h83 &&
		modulationAutoRecall |=> regAccessDenied)
		else $error("write under recall not refused");
	a_lut_mod: assert property (tempConvDone |=> lutReadEn &&
		lutSelect == 2'h0 && lutAddr == {1'b1, idxQ[6:0]})
		else $error("modulation table fetch wrong");
	a_lut_dac: assert property (tempConvDone |=> ##1
		lutSelect == 2'h1 && lutAddr == {2'b10, idxQ2[6:1]}
		##1 lutSelect == 2'h2 && lutReadEn)
		else $error("dac table fetch wrong");
	a_tick_gap: assert property (apcSampleTick |=>
		!apcSampleTick[*8])
		else $error("sample ticks too close");
	a_alarm_set: assert property ($past(nrst) |->
		(alarmFlags & $past(alarmCompare)) == $past(alarmCompare))
		else $error("alarm flag missed");
	a_qt_set: assert property ($past(nrst) |->
		(quickTripFlags & $past(quickTripCompare)) == $past(quickTripCompare))
		else $error("quick trip flag missed");
	a_warn_set: assert property ($past(nrst) |->
		(warningFlags & $past(warningCompare)) == $past(warningCompare))
		else $error("warning flag missed");
	c_recall: cover property (tempConvDone ##1 lutReadEn);
	c_denied: cover property (regAccessDenied);
	c_tick: cover property (apcSampleTick);
endmodule // laser_cfg_chk

bind laser_ctrl_config_registers laser_cfg_chk laser_cfg_chk_i (.clk,
	.nrst, .regRead, .regWrite, .regRdValid, .regAccessDenied,
	.topPasswordLevel, .lowerPasswordLevel, .tableReadPermit,
	.tableReadWritePermit, .modulationAutoRecall, .tempConvDone, .lutReadEn,
	.apcSampleTick, .regAddr, .regRdData, .temperatureIndex, .lutAddr,
	.lutSelect, .quickTripCompare, .quickTripFlags, .alarmCompare,
	.alarmFlags, .warningCompare, .warningFlags);

/* testbench/lut_model.sv */
// Lookup-table store facing the recall sequencer.
// Answers one cycle after a read request, clocked by clk.
`timescale 1ns/1ps
module lut_model (
	input  wire       clk,
	input  wire       lutReadEn,
	input  wire [7:0] lutAddr,
	input  wire [1:0] lutSelect,
	output reg  [8:0] lutData
);
	initial lutData = 9'h000;
	// Stale data flips so a late capture shows up
	always @(posedge clk) begin
		if (lutReadEn)
			lutData <= {lutSelect[0], lutAddr ^ {lutSelect, 6'h00}};
		else
			lutData <= ~lutData;
	end
endmodule // lut_model

/* testbench/tb.sv */
// Self-checking bench for the configuration register page.
// Assumes the lookup-table model and the bound checker.
`timescale 1ns/1ps
module tb;
	reg         clk, nrst, regWrite, regRead, busStop, topPasswordLevel;
	reg         lowerPasswordLevel, tableReadWritePermit, tableReadPermit;
	reg         modulationAutoRecall, auxDacOneAutoRecall, tempConvDone;
	reg         auxDacTwoAutoRecall, signalLossInput, signalLossLowAlarm;
	reg         rateSelectIn, generalInputOne, alarmClear, quickTripClear;
	reg         warningClear;
	reg  [7:0]  regAddr, regWrData, temperatureIndex, programmedAddress;
	reg  [7:0]  quickTripCompare;
	reg  [15:0] alarmCompare, warningCompare;
	wire [7:0]  regRdData, lutAddr, deviceAddress, quickTripFlags;
	wire [1:0]  lutSelect;
	wire [8:0]  lutData, modulationOut;
	wire [15:0] alarmFlags, warningFlags;
	wire        regRdValid, regAccessDenied, lutReadEn, auxDacOneOut;
	wire        auxDacTwoOut, apcSampleTick, signalLossOutput;
	wire        rateSelectOutput, generalOutputOne, alarmEnablePageFive;
	integer     mismatches = 0, num_checks = 0, i, j, n, n1;
	integer     ns [0:7] = '{800, 1200, 1600, 2000, 2800, 3200, 4400, 6400};
	reg  [15:0] seed = 16'h0006;
	reg  [7:0]  got, d;
	reg  [8:0]  v, v1, em;
	reg         den, lossExp;

	laser_ctrl_config_registers laser_ctrl_config_registers_i (.clk, .nrst,
		.regAddr, .regWrite, .regRead, .regWrData, .busStop,
		.topPasswordLevel, .lowerPasswordLevel, .tableReadWritePermit,
		.tableReadPermit, .modulationAutoRecall, .auxDacOneAutoRecall,
		.auxDacTwoAutoRecall, .temperatureIndex, .tempConvDone, .lutData,
		.programmedAddress, .signalLossInput, .signalLossLowAlarm,
		.rateSelectIn, .generalInputOne, .alarmCompare, .quickTripCompare,
		.warningCompare, .alarmClear, .quickTripClear, .warningClear,
		.regRdData, .regRdValid, .regAccessDenied, .lutAddr, .lutSelect,
		.lutReadEn, .modulationOut, .auxDacOneOut, .auxDacTwoOut,
		.apcSampleTick, .signalLossOutput, .rateSelectOutput,
		.generalOutputOne, .deviceAddress, .alarmEnablePageFive, .alarmFlags,
		.quickTripFlags, .warningFlags);
	lut_model lut_model_i (.clk, .lutReadEn, .lutAddr, .lutSelect, .lutData);

	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [8:0] lv(input [1:0] s, input [7:0] a);
		lv = {s[0], a ^ {s, 6'h00}};
	endfunction
	task tick;
		begin
			@(posedge clk);
			#2;
		end
	endtask
	task rnd;
		seed = lfsr(seed);
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("[ERR] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	// Strobe drops a cycle before the next access may raise it
	task wr(input [7:0] a, input [7:0] dd);
		begin
			regAddr = a;
			regWrData = dd;
			regWrite = 1;
			tick;
			den = regAccessDenied;
			regWrite = 0;
			tick;
		end
	endtask
	task rd(input [7:0] a);
		begin
			regAddr = a;
			regRead = 1;
			tick;
			got = regRdData;
			den = regAccessDenied;
			regRead = 0;
			tick;
		end
	endtask
	task wtick(output integer c);
		begin
			tick;
			c = 1;
			while (!apcSampleTick && c < 300) begin
				tick;
				c = c + 1;
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches = mismatches + 1;
		give_verdict;
	end
	initial begin
		{regWrite, regRead, busStop, tempConvDone, alarmClear} = 0;
		{quickTripClear, warningClear, lowerPasswordLevel} = 0;
		{tableReadWritePermit, tableReadPermit, signalLossInput} = 0;
		{signalLossLowAlarm, rateSelectIn, generalInputOne} = 0;
		{regAddr, regWrData, temperatureIndex, programmedAddress} = 0;
		{alarmCompare, warningCompare, quickTripCompare} = 0;
		topPasswordLevel = 1;
		{modulationAutoRecall, auxDacOneAutoRecall, auxDacTwoAutoRecall} = 7;
		nrst = 0;
		repeat (10) tick;
		nrst = 1;
		for (i = 8'h82; i <= 8'h8a; i = i + 1) begin
			rd(i);
			chk(got, i == 8'h89 ? 8'h80 : 8'h00);
		end
		topPasswordLevel = 0;
		rd(8'h89);
		chk({got, 7'h00, den}, 16'h0001);
		{lowerPasswordLevel, tableReadPermit} = 2'h3;
		rd(8'h89);
		chk({got, 7'h00, den}, 16'h8000);
		wr(8'h83, 8'h55);
		chk(den, 1);
		{tableReadWritePermit, tableReadPermit} = 2'h2;
		for (i = 0; i < 12; i = i + 1) begin
			rnd;
			d = seed[7:0];
			{signalLossInput, signalLossLowAlarm, rateSelectIn} = seed[10:8];
			programmedAddress = seed[15:8];
			wr(8'h89, d);
			lossExp = d[7] ? signalLossInput ^ d[5] : signalLossLowAlarm;
			chk(signalLossOutput, lossExp);
			chk(rateSelectOutput, rateSelectIn ^ d[2]);
			chk(deviceAddress, d[4] ? programmedAddress : 8'ha2);
			chk(alarmEnablePageFive, d[3]);
			rd(8'h89);
			chk(got, d & 8'hbc);
		end
		for (i = 0; i < 8; i = i + 1) begin
			generalInputOne = i[0];
			wr(8'h8a, {i[2:1], 6'h00});
			tick;
			chk(generalOutputOne, (i[2] | i[0]) ^ i[1]);
		end
		for (j = 0; j < 2; j = j + 1) begin
			wr(8'h8a, j ? 8'h07 : 8'h00);
			rnd;
			{alarmCompare, warningCompare, quickTripCompare} =
				{seed, ~seed, seed[7:0]};
			tick;
			{alarmCompare, warningCompare, quickTripCompare} = 0;
			tick;
			tick;
			chk(alarmFlags, j ? seed : 16'h0000);
			chk(warningFlags, j ? ~seed : 16'h0000);
			chk(quickTripFlags, j ? seed[7:0] : 8'h00);
		end
		{alarmClear, quickTripClear, warningClear} = 3'h7;
		tick;
		{alarmClear, quickTripClear, warningClear} = 3'h0;
		tick;
		chk(alarmFlags | warningFlags | quickTripFlags, 0);
		wr(8'h83, 8'h55);
		chk(den, 1);
		{modulationAutoRecall, auxDacOneAutoRecall, auxDacTwoAutoRecall} = 0;
		for (j = 0; j < 3; j = j + 1) begin
			rnd;
			v = seed[8:0];
			if (j == 0)
				em = v;
			if (j == 1)
				v1 = v;
			wr(8'h82 + 2 * j, {7'h00, v[8]});
			wr(8'h83 + 2 * j, v[7:0]);
			chk(den, 0);
			rd(8'h82 + 2 * j);
			chk(got, v[8]);
			rd(8'h83 + 2 * j);
			chk(got, v[7:0]);
		end
		chk(modulationOut, 0);
		busStop = 1;
		tick;
		busStop = 0;
		tick;
		tick;
		chk(modulationOut, em);
		n = 0;
		n1 = 0;
		// Any 512 steps at a fixed value carry out exactly that value
		repeat (512) begin
			tick;
			n = n + auxDacTwoOut;
			n1 = n1 + auxDacOneOut;
		end
		chk(n, v);
		chk(n1, v1);
		for (j = 0; j < 4; j = j + 1) begin
			rnd;
			temperatureIndex = seed[7:0];
			modulationAutoRecall = (j != 0);
			{auxDacOneAutoRecall, auxDacTwoAutoRecall} = 2'h3;
			if (j != 0)
				em = lv(0, {1'b1, seed[6:0]});
			tempConvDone = 1;
			tick;
			tempConvDone = 0;
			repeat (6) tick;
			chk(modulationOut, em);
			rd(8'h84);
			d = got;
			rd(8'h85);
			chk({d[0], got}, lv(1, {2'b10, seed[6:1]}));
			rd(8'h86);
			d = got;
			rd(8'h87);
			chk({d[0], got}, lv(2, {2'b10, seed[6:1]}));
		end
		for (j = 0; j < 8; j = j + 1) begin
			wr(8'h88, {5'h1f, j[2:0]});
			rd(8'h88);
			chk(got, j);
			wtick(n);
			wtick(n);
			chk(n, ns[j] / 25);
		end
		nrst = 0;
		tick;
		nrst = 1;
		rd(8'h88);
		chk(got, 0);
		rd(8'h89);
		chk(got, 8'h80);
		give_verdict;
	end
endmodule // tb

/* verilog/delta_sigma_dac.v */
// First-order delta-sigma bit stream for a 9-bit value.
// Assumes an external filter referenced to the DAC reference input.
`timescale 1ns/1ps
module delta_sigma_dac (
	input  wire       clk,
	input  wire       nrst,
	input  wire [8:0] value,
	output reg        bitOut
);
	reg  [8:0] acc_reg;
	wire [9:0] sum;

	// Pulse density is value/512 of full scale
	assign sum = {1'b0, acc_reg} + {1'b0, value};

	always @(posedge clk) begin
		if (!nrst) begin
			acc_reg <= 9'h000;
			bitOut  <= 1'b0;
		end else begin
			acc_reg <= sum[8:0];
			bitOut  <= sum[9];
		end
	end
endmodule // delta_sigma_dac

/* verilog/flag_latch.v */
// Comparison flags that either mirror or stick, per latch mode.
// Assumes compare is refreshed by the monitor each cycle.
`timescale 1ns/1ps
module flag_latch #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             nrst,
	input  wire             latchMode,
	input  wire [WIDTH-1:0] compare,
	input  wire             clear,
	output reg  [WIDTH-1:0] flags
);
	always @(posedge clk) begin
		if (!nrst) begin
			flags <= {WIDTH{1'b0}};
		end else if (latchMode) begin
			// New set wins over a clear in the same cycle
			flags <= (clear ? {WIDTH{1'b0}} : flags) | compare;
		end else begin
			flags <= compare;
		end
	end
endmodule // flag_latch

/* verilog/laser_cfg_consts.vh */
// Offsets, field positions, reset values and timing counts
// for the configuration register page. Definitions only.
`ifndef LASER_CFG_CONSTS_VH
`define LASER_CFG_CONSTS_VH

// Byte offsets within the page
`define OFS_MOD_HI      8'h82
`define OFS_MOD_LO      8'h83
`define OFS_DAC1_HI     8'h84
`define OFS_DAC1_LO     8'h85
`define OFS_DAC2_HI     8'h86
`define OFS_DAC2_LO     8'h87
`define OFS_APC_PERIOD  8'h88
`define OFS_ROUTING     8'h89
`define OFS_LATCH       8'h8a

// Reset values
`define RST_VALUE       9'h000
`define RST_APC_PERIOD  3'h0
`define RST_ROUTING     8'h80
`define RST_LATCH       8'h00

// Writable bits of the two configuration bytes
`define ROUTING_WMASK   8'hbc
`define LATCH_WMASK     8'hc7

// Routing byte fields
`define BIT_LOSS_SRC    7
`define BIT_LOSS_INV    5
`define BIT_ADDR_SEL    4
`define BIT_ALM_PAGE    3
`define BIT_RSEL_INV    2

// Latch byte fields
`define BIT_GENERAL_OUTPUT_ONE_FORCE  7
`define BIT_GENERAL_OUTPUT_ONE_POL    6
`define BIT_ALM_LATCH   2
`define BIT_QT_LATCH    1
`define BIT_WARN_LATCH  0

// Fixed serial address when address select is clear
`define FIXED_DEV_ADDR  8'ha2

// Lookup table selects
`define LUT_SEL_MOD     2'h0
`define LUT_SEL_DAC1    2'h1
`define LUT_SEL_DAC2    2'h2

// Clock and APC sample periods
`define CLK_PERIOD_NS   25
`define APC_NS_0        800
`define APC_NS_1        1200
`define APC_NS_2        1600
`define APC_NS_3        2000
`define APC_NS_4        2800
`define APC_NS_5        3200
`define APC_NS_6        4400
`define APC_NS_7        6400
`define APC_CYC_0       (`APC_NS_0 / `CLK_PERIOD_NS)
`define APC_CYC_1       (`APC_NS_1 / `CLK_PERIOD_NS)
`define APC_CYC_2       (`APC_NS_2 / `CLK_PERIOD_NS)
`define APC_CYC_3       (`APC_NS_3 / `CLK_PERIOD_NS)
`define APC_CYC_4       (`APC_NS_4 / `CLK_PERIOD_NS)
`define APC_CYC_5       (`APC_NS_5 / `CLK_PERIOD_NS)
`define APC_CYC_6       (`APC_NS_6 / `CLK_PERIOD_NS)
`define APC_CYC_7       (`APC_NS_7 / `CLK_PERIOD_NS)

`endif

/* verilog/laser_ctrl_config_registers.v */
// Configuration and output-value register page of the module
// controller. Assumes a serial-bus slave that presents byte
// accesses within this page and a STOP pulse, and a lookup-table
// store with one cycle of read latency.
`timescale 1ns/1ps
`include "laser_cfg_consts.vh"

// Functional notes
// - Modulation value reloads from its table per temperature conversion.
// - First DAC value reloads from its table per temperature conversion.
// - Second DAC value reloads from its table per temperature conversion.
// - Value registers are 9 bits, bit 8 in low bit of upper byte.
// - Modulation write needs recall off and top or lower-with-write password.
// - First DAC write needs recall off and the write password condition.
// - Second DAC write needs recall off and the write password condition.
// - Reads need top password, or lower with read or read-write permit.
// - DAC outputs scale as reference times value over 512.
// - Three-bit select picks APC sample period from 800 to 6400 ns.
// - Loss output source: low alarm when 0, input pin when 1.
// - Loss invert bit inverts the buffered input onto the output.
// - Address select clear answers at A2h, set uses programmed byte.
// - Alarm-enable page bit swaps the alarm-enable row between pages.
// - Rate-select invert bit inverts the rate-select output pin.
// - Output one follows input one, or is forced active by software.
// - Polarity bit inverts the active state of output one.
// - Alarm latch bit makes alarm flags stick once set.
// - Quick-trip latch bit makes quick-trip flags stick once set.
// - Warning latch bit makes warning flags stick once set.
// - With modulation recall off, host value applies at bus STOP.
// - With DAC recall off, host value applies at STOP; else automatic.
// - Modulation table at 1,index[6:0]; DAC tables at 1,0,index[6:1].
module laser_ctrl_config_registers (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  regAddr,
	input  wire        regWrite,
	input  wire        regRead,
	input  wire [7:0]  regWrData,
	input  wire        busStop,
	input  wire        topPasswordLevel,
	input  wire        lowerPasswordLevel,
	input  wire        tableReadWritePermit,
	input  wire        tableReadPermit,
	input  wire        modulationAutoRecall,
	input  wire        auxDacOneAutoRecall,
	input  wire        auxDacTwoAutoRecall,
	input  wire [7:0]  temperatureIndex,
	input  wire        tempConvDone,
	input  wire [8:0]  lutData,
	input  wire [7:0]  programmedAddress,
	input  wire        signalLossInput,
	input  wire        signalLossLowAlarm,
	input  wire        rateSelectIn,
	input  wire        generalInputOne,
	input  wire [15:0] alarmCompare,
	input  wire [7:0]  quickTripCompare,
	input  wire [15:0] warningCompare,
	input  wire        alarmClear,
	input  wire        quickTripClear,
	input  wire        warningClear,
	output reg  [7:0]  regRdData,
	output reg         regRdValid,
	output reg         regAccessDenied,
	output reg  [7:0]  lutAddr,
	output reg  [1:0]  lutSelect,
	output reg         lutReadEn,
	output reg  [8:0]  modulationOut,
	output wire        auxDacOneOut,
	output wire        auxDacTwoOut,
	output reg         apcSampleTick,
	output reg         signalLossOutput,
	output reg         rateSelectOutput,
	output reg         generalOutputOne,
	output reg  [7:0]  deviceAddress,
	output reg         alarmEnablePageFive,
	output wire [15:0] alarmFlags,
	output wire [7:0]  quickTripFlags,
	output wire [15:0] warningFlags
);
	localparam S_IDLE = 3'd0;
	localparam S_MOD  = 3'd1;
	localparam S_DAC1 = 3'd2;
	localparam S_DAC2 = 3'd3;
	localparam S_DONE = 3'd4;

	// Value registers: 0 modulation, 1 first DAC, 2 second DAC
	reg  [8:0] value_reg   [0:2];
	reg  [8:0] applied_reg [0:2];
	reg  [2:0] pending_reg;
	reg  [2:0] apcSel_reg;
	reg  [7:0] routing_reg;
	reg  [7:0] latchCfg_reg;
	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [6:0] index_reg;
	reg  [8:0] apcCount_reg;
	reg  [7:0] rdData_next;

	wire       readOk;
	wire       writeOk;
	wire [2:0] recallOn;
	wire [8:0] apcPeriod;

	assign recallOn = {auxDacTwoAutoRecall, auxDacOneAutoRecall,
		modulationAutoRecall};

	// Sample period in clock cycles for a select code
	function [8:0] apcCycles;
		input [2:0] sel;
		reg   [31:0] cycles;
		begin
			case (sel)
				3'h0: cycles = `APC_CYC_0;
				3'h1: cycles = `APC_CYC_1;
				3'h2: cycles = `APC_CYC_2;
				3'h3: cycles = `APC_CYC_3;
				3'h4: cycles = `APC_CYC_4;
				3'h5: cycles = `APC_CYC_5;
				3'h6: cycles = `APC_CYC_6;
				default: cycles = `APC_CYC_7;
			endcase
			// Longest period is 256 cycles, fits nine bits
			apcCycles = cycles[8:0];
		end
	endfunction

	// Which value register an offset hits, 3 for none
	function [1:0] valueSlot;
		input [7:0] addr;
		begin
			case (addr)
				`OFS_MOD_HI, `OFS_MOD_LO:   valueSlot = 2'd0;
				`OFS_DAC1_HI, `OFS_DAC1_LO: valueSlot = 2'd1;
				`OFS_DAC2_HI, `OFS_DAC2_LO: valueSlot = 2'd2;
				default:                    valueSlot = 2'd3;
			endcase
		end
	endfunction

	assign readOk = topPasswordLevel | (lowerPasswordLevel &
		(tableReadWritePermit | tableReadPermit));
	assign writeOk = topPasswordLevel |
		(lowerPasswordLevel & tableReadWritePermit);

	assign apcPeriod = apcCycles(apcSel_reg);

	// recall sequence: one table per cycle
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (tempConvDone)
					state_next = S_MOD;
			end
			S_MOD:   state_next = S_DAC1;
			S_DAC1:  state_next = S_DAC2;
			S_DAC2:  state_next = S_DONE;
			S_DONE:  state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			index_reg <= 7'h00;
			lutAddr   <= 8'h00;
			lutSelect <= `LUT_SEL_MOD;
			lutReadEn <= 1'b0;
		end else begin
			state_reg <= state_next;
			lutReadEn <= 1'b0;
			case (state_next)
				S_MOD: begin
					index_reg <= temperatureIndex[6:0];
					lutAddr   <= {1'b1, temperatureIndex[6:0]};
					lutSelect <= `LUT_SEL_MOD;
					lutReadEn <= 1'b1;
				end
				S_DAC1: begin
					lutAddr   <= {2'b10, index_reg[6:1]};
					lutSelect <= `LUT_SEL_DAC1;
					lutReadEn <= 1'b1;
				end
				S_DAC2: begin
					lutAddr   <= {2'b10, index_reg[6:1]};
					lutSelect <= `LUT_SEL_DAC2;
					lutReadEn <= 1'b1;
				end
				default: begin
					lutAddr   <= lutAddr;
					lutSelect <= lutSelect;
				end
			endcase
		end
	end

	// Value registers, recall capture and STOP-time apply
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gValue
			wire capture;
			wire hostWr;
			// Data for slot g arrives one state after its address
			assign capture = recallOn[g] &&
				(state_reg == g + 2);
			assign hostWr = regWrite && writeOk && !recallOn[g] &&
				(valueSlot(regAddr) == g);

			always @(posedge clk) begin
				if (!nrst) begin
					value_reg[g]   <= `RST_VALUE;
					applied_reg[g] <= `RST_VALUE;
					pending_reg[g] <= 1'b0;
				end else if (capture) begin
					value_reg[g]   <= lutData;
					applied_reg[g] <= lutData;
					pending_reg[g] <= 1'b0;
				end else begin
					if (hostWr) begin
						// bit 8 lives in upper byte bit 0
						if (regAddr[0] == 1'b0)
							value_reg[g][8] <= regWrData[0];
						else
							value_reg[g][7:0] <= regWrData;
					end
					if (busStop) begin
						if (pending_reg[g])
							applied_reg[g] <= value_reg[g];
						// A write in the STOP cycle waits for the next STOP
						pending_reg[g] <= hostWr;
					end else if (hostWr) begin
						pending_reg[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Configuration byte writes
	always @(posedge clk) begin
		if (!nrst) begin
			apcSel_reg   <= `RST_APC_PERIOD;
			routing_reg  <= `RST_ROUTING;
			latchCfg_reg <= `RST_LATCH;
		end else if (regWrite && writeOk) begin
			case (regAddr)
				`OFS_APC_PERIOD: apcSel_reg <= regWrData[2:0];
				`OFS_ROUTING:
					routing_reg <= regWrData & `ROUTING_WMASK;
				`OFS_LATCH:
					latchCfg_reg <= regWrData & `LATCH_WMASK;
				default: apcSel_reg <= apcSel_reg;
			endcase
		end
	end

	// read data, bits 7:1 of value upper bytes read zero
	always @* begin
		case (regAddr)
			`OFS_MOD_HI:     rdData_next = {7'h00, value_reg[0][8]};
			`OFS_MOD_LO:     rdData_next = value_reg[0][7:0];
			`OFS_DAC1_HI:    rdData_next = {7'h00, value_reg[1][8]};
			`OFS_DAC1_LO:    rdData_next = value_reg[1][7:0];
			`OFS_DAC2_HI:    rdData_next = {7'h00, value_reg[2][8]};
			`OFS_DAC2_LO:    rdData_next = value_reg[2][7:0];
			`OFS_APC_PERIOD: rdData_next = {5'h00, apcSel_reg};
			`OFS_ROUTING:    rdData_next = routing_reg;
			`OFS_LATCH:      rdData_next = latchCfg_reg;
			default:         rdData_next = 8'h00;
		endcase
		if (!readOk)
			rdData_next = 8'h00;
	end

	always @(posedge clk) begin
		if (!nrst) begin
			regRdData       <= 8'h00;
			regRdValid      <= 1'b0;
			regAccessDenied <= 1'b0;
		end else begin
			regRdValid <= regRead;
			if (regRead)
				regRdData <= rdData_next;
			// Refused accesses are flagged for the bus slave to NACK
			regAccessDenied <= (regRead && !readOk) ||
				(regWrite && (!writeOk || (valueSlot(regAddr) != 2'd3
				&& recallOn[valueSlot(regAddr)])));
		end
	end

	// APC sample tick every selected period
	always @(posedge clk) begin
		if (!nrst) begin
			apcCount_reg  <= 9'h000;
			apcSampleTick <= 1'b0;
		end else if (apcCount_reg >= apcPeriod - 9'h001) begin
			apcCount_reg  <= 9'h000;
			apcSampleTick <= 1'b1;
		end else begin
			apcCount_reg  <= apcCount_reg + 9'h001;
			apcSampleTick <= 1'b0;
		end
	end

	// Pin routing and address selection
	always @(posedge clk) begin
		if (!nrst) begin
			modulationOut       <= `RST_VALUE;
			signalLossOutput    <= 1'b0;
			rateSelectOutput    <= 1'b0;
			generalOutputOne    <= 1'b0;
			deviceAddress       <= `FIXED_DEV_ADDR;
			alarmEnablePageFive <= 1'b0;
		end else begin
			modulationOut <= applied_reg[0];
			if (routing_reg[`BIT_LOSS_SRC])
				signalLossOutput <= signalLossInput ^
					routing_reg[`BIT_LOSS_INV];
			else
				signalLossOutput <= signalLossLowAlarm;
			rateSelectOutput <= rateSelectIn ^
				routing_reg[`BIT_RSEL_INV];
			generalOutputOne <= (latchCfg_reg[`BIT_GENERAL_OUTPUT_ONE_FORCE] |
				generalInputOne) ^ latchCfg_reg[`BIT_GENERAL_OUTPUT_ONE_POL];
			deviceAddress <= routing_reg[`BIT_ADDR_SEL] ?
				programmedAddress : `FIXED_DEV_ADDR;
			alarmEnablePageFive <= routing_reg[`BIT_ALM_PAGE];
		end
	end

	delta_sigma_dac uDacOne (
		.clk    (clk),
		.nrst   (nrst),
		.value  (applied_reg[1]),
		.bitOut (auxDacOneOut)
	);

	delta_sigma_dac uDacTwo (
		.clk    (clk),
		.nrst   (nrst),
		.value  (applied_reg[2]),
		.bitOut (auxDacTwoOut)
	);

	flag_latch #(.WIDTH(16)) uAlarm (
		.clk       (clk),
		.nrst      (nrst),
		.latchMode (latchCfg_reg[`BIT_ALM_LATCH]),
		.compare   (alarmCompare),
		.clear     (alarmClear),
		.flags     (alarmFlags)
	);

	flag_latch #(.WIDTH(8)) uQuickTrip (
		.clk       (clk),
		.nrst      (nrst),
		.latchMode (latchCfg_reg[`BIT_QT_LATCH]),
		.compare   (quickTripCompare),
		.clear     (quickTripClear),
		.flags     (quickTripFlags)
	);

	flag_latch #(.WIDTH(16)) uWarning (
		.clk       (clk),
		.nrst      (nrst),
		.latchMode (latchCfg_reg[`BIT_WARN_LATCH]),
		.compare   (warningCompare),
		.clear     (warningClear),
		.flags     (warningFlags)
	);
endmodule // laser_ctrl_config_registers
